// ### design/dcfpc_map.vh
// Constants of the dual-clock FIFO port control: widths, presets, mode codes, counts.
// Assumes inclusion by bare name from the design file.
`ifndef DCFPC_MAP_VH
`define DCFPC_MAP_VH

// Data and offset widths, FIFO depth and address width
`define DCFPC_DATA_W        36
`define DCFPC_OFFSET_W      9
`define DCFPC_FIFO_DEPTH    16
`define DCFPC_FIFO_AW       4

// Serial programming length and chain layout
`define DCFPC_SERIAL_BITS   5'h12
`define DCFPC_SERIAL_CNT_W  5
`define DCFPC_CHAIN_W       18
`define DCFPC_CHAIN_Y_MSB   17
`define DCFPC_CHAIN_Y_LSB   9
`define DCFPC_CHAIN_X_MSB   8
`define DCFPC_CHAIN_X_LSB   0

// Offset method codes, {flag select high, flag select low}
`define DCFPC_MODE_PARALLEL 2'h0
`define DCFPC_MODE_PRESET8  2'h1
`define DCFPC_MODE_PRESET64 2'h2
`define DCFPC_MODE_SERIAL   2'h3

// Preset offset values
`define DCFPC_PRESET_8      9'h008
`define DCFPC_PRESET_64     9'h040

// Reset values
`define DCFPC_RST_OFFSET    9'h000
`define DCFPC_RST_MODE      2'h0
`define DCFPC_RST_MBOX      36'h000000000

// Port-A edges after reset release before input ready rises
`define DCFPC_ARM_EDGES     2'h2

`endif

// ### design/dcfpc_top.v
// Port control of a 36-bit FIFO from port A to port B: strobes, input ready,
// serial offset load, mailboxes. Port clocks and all pins are sampled on sys_clk_i,
// which must run well above both port clocks.
`timescale 1ns/1ps
`include "dcfpc_map.vh"

module dcfpc_sync #(
    parameter W = 1
) (
    input  wire         sys_clk_i,
    input  wire         rst_i,
    input  wire [W-1:0] d_i,
    output reg  [W-1:0] q_o
);
    // Only q_o reads the first stage
    reg [W-1:0] meta;

    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta <= {W{1'b0}};
            q_o  <= {W{1'b0}};
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule // dcfpc_sync

module dcfpc_fifo #(
    parameter W     = 36,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire         sys_clk_i,
    input  wire         rst_i,
    input  wire         clear_i,
    input  wire         in_valid_i,
    output wire         in_ready_o,
    input  wire [W-1:0] in_data_i,
    output wire         out_valid_o,
    input  wire         out_ready_i,
    output wire [W-1:0] out_data_o
);
    reg [W-1:0] mem [0:DEPTH-1];
    // Pointers carry one extra wrap bit to tell full from empty
    reg [AW:0]  wr_ptr;
    reg [AW:0]  rd_ptr;
    wire        push;
    wire        pop;

    assign out_valid_o = (wr_ptr != rd_ptr);
    assign in_ready_o  = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) || (wr_ptr[AW] == rd_ptr[AW]);
    assign out_data_o  = mem[rd_ptr[AW-1:0]];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_ready_i & out_valid_o;

    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end else if (clear_i) begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + {{AW{1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr <= rd_ptr + {{AW{1'b0}}, 1'b1};
            end
        end
    end

    always @(posedge sys_clk_i) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end
endmodule // dcfpc_fifo

module dcfpc_top #(
    parameter DW    = `DCFPC_DATA_W,
    parameter OW    = `DCFPC_OFFSET_W,
    parameter DEPTH = `DCFPC_FIFO_DEPTH,
    parameter AW    = `DCFPC_FIFO_AW
) (
    // System
    input  wire          sys_clk_i,
    input  wire          rst_i,
    // Device reset pin
    input  wire          dev_reset_n_i,
    // Flag select / serial pins
    input  wire          flag_sel_hi_serial_en_n_i,
    input  wire          flag_sel_lo_serial_bit_i,
    // Port A
    input  wire          port_a_clock_i,
    input  wire          port_a_chip_select_n_i,
    input  wire          port_a_master_enable_i,
    input  wire          port_a_write_not_read_i,
    input  wire          port_a_mailbox_select_i,
    input  wire [DW-1:0] port_a_data_i,
    output reg  [DW-1:0] port_a_data_o,
    output reg           port_a_data_oe_o,
    output reg           input_ready_o,
    output reg           b_to_a_mailbox_flag_n_o,
    // Port B
    input  wire          port_b_clock_i,
    input  wire          port_b_chip_select_n_i,
    input  wire          port_b_master_enable_i,
    input  wire          port_b_read_not_write_i,
    input  wire          port_b_mailbox_select_i,
    input  wire [DW-1:0] port_b_data_i,
    output reg  [DW-1:0] port_b_data_o,
    output reg           port_b_data_oe_o,
    output reg           a_to_b_mailbox_flag_n_o,
    // Retransmit mark reached by write position
    input  wire          retransmit_block_i,
    // FIFO state and offsets
    output reg           fifo_not_empty_o,
    output reg  [1:0]    offset_mode_o,
    output reg  [OW-1:0] almost_full_offset_o,
    output reg  [OW-1:0] almost_empty_offset_o
);
    localparam AIN = DW + 5;
    localparam BIN = DW + 5;

    wire [AIN-1:0] a_s;
    wire [BIN-1:0] b_s;
    wire [2:0]     m_s;
    reg            a_clk_d;
    reg            b_clk_d;
    reg            rstn_d;
    reg            a_edge_q;
    reg  [1:0]     arm_cnt;
    reg  [`DCFPC_SERIAL_CNT_W-1:0] ser_cnt;
    reg  [DW-1:0]  a_to_b_mailbox;
    reg  [DW-1:0]  b_to_a_mailbox;
    wire           fifo_in_ready;
    wire           fifo_out_valid;
    wire [DW-1:0]  fifo_out_data;

    dcfpc_sync #(.W(AIN)) u_sync_a (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .d_i       ({port_a_clock_i, port_a_chip_select_n_i, port_a_master_enable_i,
                     port_a_write_not_read_i, port_a_mailbox_select_i, port_a_data_i}),
        .q_o       (a_s)
    );

    dcfpc_sync #(.W(BIN)) u_sync_b (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .d_i       ({port_b_clock_i, port_b_chip_select_n_i, port_b_master_enable_i,
                     port_b_read_not_write_i, port_b_mailbox_select_i, port_b_data_i}),
        .q_o       (b_s)
    );

    dcfpc_sync #(.W(3)) u_sync_m (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .d_i       ({dev_reset_n_i, flag_sel_hi_serial_en_n_i, flag_sel_lo_serial_bit_i}),
        .q_o       (m_s)
    );

    wire          a_clk   = a_s[DW+4];
    wire          a_cs_n  = a_s[DW+3];
    wire          a_en    = a_s[DW+2];
    wire          a_wnr   = a_s[DW+1];
    wire          a_mb    = a_s[DW];
    wire [DW-1:0] a_data  = a_s[DW-1:0];
    wire          b_clk   = b_s[DW+4];
    wire          b_cs_n  = b_s[DW+3];
    wire          b_en    = b_s[DW+2];
    wire          b_rnw   = b_s[DW+1];
    wire          b_mb    = b_s[DW];
    wire [DW-1:0] b_data  = b_s[DW-1:0];
    wire          rstn    = m_s[2];
    wire          fs_hi   = m_s[1];
    wire          fs_lo   = m_s[0];

    wire dev_rst   = ~rstn;
    wire rst_rise  = rstn & ~rstn_d;
    wire a_edge    = a_clk & ~a_clk_d & rstn;
    wire b_edge    = b_clk & ~b_clk_d & rstn;
    wire a_sel     = a_edge & ~a_cs_n & a_en;
    wire b_sel     = b_edge & ~b_cs_n & b_en;
    wire a_wr      = a_sel & a_wnr;
    wire a_rd      = a_sel & ~a_wnr;
    wire b_wr      = b_sel & ~b_rnw;
    wire b_rd      = b_sel & b_rnw;
    wire serial    = (offset_mode_o == `DCFPC_MODE_SERIAL);
    wire ser_done  = (ser_cnt == `DCFPC_SERIAL_BITS);
    wire ser_shift = serial & a_edge & ~fs_hi & ~ser_done;
    wire armed     = (arm_cnt == `DCFPC_ARM_EDGES) & (~serial | ser_done);
    wire fifo_push = a_wr & ~a_mb & input_ready_o & fifo_in_ready;
    wire fifo_pop  = b_rd & ~b_mb & fifo_out_valid;
    wire next_ir   = armed & fifo_in_ready & ~retransmit_block_i & ~dev_rst;
    wire [`DCFPC_CHAIN_W-1:0] chain = {almost_full_offset_o, almost_empty_offset_o};
    wire [`DCFPC_CHAIN_W-1:0] next_chain = {chain[`DCFPC_CHAIN_W-2:0], fs_lo};

    dcfpc_fifo #(.W(DW), .DEPTH(DEPTH), .AW(AW)) u_fifo (
        .sys_clk_i   (sys_clk_i),
        .rst_i       (rst_i),
        .clear_i     (dev_rst),
        .in_valid_i  (fifo_push),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (a_data),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_pop),
        .out_data_o  (fifo_out_data)
    );

    // Edge detectors reset low, the port clocks' idle level, so no false clock edge appears
    // when reset is released; rstn_d also resets low, so rst_rise fires once after release
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            a_clk_d  <= 1'b0;
            b_clk_d  <= 1'b0;
            rstn_d   <= 1'b0;
            a_edge_q <= 1'b0;
        end else begin
            a_clk_d  <= a_clk;
            b_clk_d  <= b_clk;
            rstn_d   <= rstn;
            a_edge_q <= a_edge;
        end
    end

    // Port-A edges counted after device reset before input ready may rise
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            arm_cnt <= 2'h0;
        end else if (dev_rst) begin
            arm_cnt <= 2'h0;
        end else if (a_edge && arm_cnt != `DCFPC_ARM_EDGES) begin
            arm_cnt <= arm_cnt + 2'h1;
        end
    end

    // Serial bits taken; stops at eighteen so later bits are ignored
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ser_cnt <= {`DCFPC_SERIAL_CNT_W{1'b0}};
        end else if (dev_rst) begin
            ser_cnt <= {`DCFPC_SERIAL_CNT_W{1'b0}};
        end else if (ser_shift) begin
            ser_cnt <= ser_cnt + {{(`DCFPC_SERIAL_CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // Offset method and offset registers
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            offset_mode_o         <= `DCFPC_RST_MODE;
            almost_full_offset_o  <= `DCFPC_RST_OFFSET;
            almost_empty_offset_o <= `DCFPC_RST_OFFSET;
        end else if (rst_rise) begin
            offset_mode_o <= {fs_hi, fs_lo};
            case ({fs_hi, fs_lo})
                `DCFPC_MODE_PRESET64: begin
                    almost_full_offset_o  <= `DCFPC_PRESET_64;
                    almost_empty_offset_o <= `DCFPC_PRESET_64;
                end
                `DCFPC_MODE_PRESET8: begin
                    almost_full_offset_o  <= `DCFPC_PRESET_8;
                    almost_empty_offset_o <= `DCFPC_PRESET_8;
                end
                default: begin
                    almost_full_offset_o  <= `DCFPC_RST_OFFSET;
                    almost_empty_offset_o <= `DCFPC_RST_OFFSET;
                end
            endcase
        end else if (ser_shift) begin
            almost_full_offset_o  <= next_chain[`DCFPC_CHAIN_Y_MSB:`DCFPC_CHAIN_Y_LSB];
            almost_empty_offset_o <= next_chain[`DCFPC_CHAIN_X_MSB:`DCFPC_CHAIN_X_LSB];
        end
    end

    // A-to-B mailbox and flag; new mail wins over a same-cycle port-B read
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            a_to_b_mailbox          <= `DCFPC_RST_MBOX;
            a_to_b_mailbox_flag_n_o <= 1'b1;
        end else if (dev_rst) begin
            a_to_b_mailbox_flag_n_o <= 1'b1;
        end else if (a_wr && a_mb) begin
            a_to_b_mailbox          <= a_data;
            a_to_b_mailbox_flag_n_o <= 1'b0;
        end else if (b_rd && b_mb) begin
            a_to_b_mailbox_flag_n_o <= 1'b1;
        end
    end

    // B-to-A mailbox and flag; new mail wins over a same-cycle port-A read
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            b_to_a_mailbox          <= `DCFPC_RST_MBOX;
            b_to_a_mailbox_flag_n_o <= 1'b1;
        end else if (dev_rst) begin
            b_to_a_mailbox_flag_n_o <= 1'b1;
        end else if (b_wr && b_mb) begin
            b_to_a_mailbox          <= b_data;
            b_to_a_mailbox_flag_n_o <= 1'b0;
        end else if (a_rd && a_mb) begin
            b_to_a_mailbox_flag_n_o <= 1'b1;
        end
    end

    // Input ready is updated only in the cycle after a port-A edge, keeping it
    // synchronous to port A; device reset and the retransmit mark force it low in any cycle
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            input_ready_o <= 1'b0;
        end else if (dev_rst || retransmit_block_i) begin
            input_ready_o <= 1'b0;
        end else if (a_edge_q) begin
            input_ready_o <= next_ir;
        end
    end

    // Port-A data driver
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            port_a_data_o    <= {DW{1'b0}};
            port_a_data_oe_o <= 1'b0;
        end else begin
            port_a_data_o    <= b_to_a_mailbox;
            port_a_data_oe_o <= ~a_cs_n & ~a_wnr;
        end
    end

    // Port-B data driver and FIFO fill state
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fifo_not_empty_o <= 1'b0;
            port_b_data_o    <= {DW{1'b0}};
            port_b_data_oe_o <= 1'b0;
        end else begin
            fifo_not_empty_o <= fifo_out_valid;
            port_b_data_o    <= b_mb ? a_to_b_mailbox : fifo_out_data;
            port_b_data_oe_o <= ~b_cs_n & b_rnw;
        end
    end
endmodule // dcfpc_top

// ### bench/dcfpc_asserts.sv
// Concurrent checks on the outputs of dcfpc_top against its pins.
// Bound to every dcfpc_top instance and sees only that instance's ports.
`timescale 1ns/1ps

module dcfpc_asserts #(
    parameter OW = 9
) (
    // System, device reset and flag select pins
    input wire          sys_clk_i,
    input wire          rst_i,
    input wire          dev_reset_n_i,
    input wire          flag_sel_hi_serial_en_n_i,
    input wire          flag_sel_lo_serial_bit_i,
    // Port A
    input wire          port_a_clock_i,
    input wire          port_a_chip_select_n_i,
    input wire          port_a_master_enable_i,
    input wire          port_a_write_not_read_i,
    input wire          port_a_mailbox_select_i,
    input wire          port_a_data_oe_o,
    input wire          input_ready_o,
    input wire          b_to_a_mailbox_flag_n_o,
    // Port B
    input wire          port_b_chip_select_n_i,
    input wire          port_b_master_enable_i,
    input wire          port_b_read_not_write_i,
    input wire          port_b_mailbox_select_i,
    input wire          port_b_data_oe_o,
    input wire          a_to_b_mailbox_flag_n_o,
    // Retransmit and offsets
    input wire          retransmit_block_i,
    input wire [1:0]    offset_mode_o,
    input wire [OW-1:0] almost_full_offset_o,
    input wire [OW-1:0] almost_empty_offset_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    // Pins reach outputs through two sync flops and one register; input ready adds a_edge_q, retransmit_block_i has no sync
    oe_a_off_a:
        assert property (port_a_chip_select_n_i [*5] |-> !port_a_data_oe_o) else $error("port A drives while off");
    oe_b_off_a:
        assert property (port_b_chip_select_n_i [*5] |-> !port_b_data_oe_o) else $error("port B drives while off");
    a2b_set_a:
        assert property ($fell(a_to_b_mailbox_flag_n_o) |-> $past(port_a_write_not_read_i, 4)
            && $past(port_a_mailbox_select_i, 4) && $past(port_a_master_enable_i, 4)
            && !$past(port_a_chip_select_n_i, 4)) else $error("A-to-B flag low without write");
    b2a_set_a:
        assert property ($fell(b_to_a_mailbox_flag_n_o) |-> !$past(port_b_read_not_write_i, 4)
            && $past(port_b_mailbox_select_i, 4) && $past(port_b_master_enable_i, 4)
            && !$past(port_b_chip_select_n_i, 4)) else $error("B-to-A flag low without write");
    a2b_clear_a:
        assert property ($rose(a_to_b_mailbox_flag_n_o) |-> !$past(dev_reset_n_i, 3) || !$past(dev_reset_n_i, 4)
            || ($past(port_b_read_not_write_i, 4) && $past(port_b_mailbox_select_i, 4)
            && $past(port_b_master_enable_i, 4) && !$past(port_b_chip_select_n_i, 4)))
            else $error("A-to-B flag high without read");
    b2a_clear_a:
        assert property ($rose(b_to_a_mailbox_flag_n_o) |-> !$past(dev_reset_n_i, 3) || !$past(dev_reset_n_i, 4)
            || (!$past(port_a_write_not_read_i, 4) && $past(port_a_mailbox_select_i, 4)
            && $past(port_a_master_enable_i, 4) && !$past(port_a_chip_select_n_i, 4)))
            else $error("B-to-A flag high without read");
    ir_reset_a:
        assert property (!dev_reset_n_i [*5] |-> !input_ready_o) else $error("input ready high in reset");
    mbox_reset_a:
        assert property (!dev_reset_n_i [*5] |-> a_to_b_mailbox_flag_n_o && b_to_a_mailbox_flag_n_o)
            else $error("mailbox flag low in reset");
    mode_latch_a:
        assert property ($changed(offset_mode_o) |-> offset_mode_o
            == {$past(flag_sel_hi_serial_en_n_i, 4), $past(flag_sel_lo_serial_bit_i, 4)}) else $error("bad mode");
    preset_64_a:
        assert property ((offset_mode_o == 2'h2) [*2] |-> almost_full_offset_o == 9'h040
            && almost_empty_offset_o == 9'h040) else $error("preset offsets not 64");
    ir_sync_a:
        assert property ($rose(input_ready_o) |-> $past(port_a_clock_i, 4) && !$past(port_a_clock_i, 5))
            else $error("input ready rose off a port-A edge");
    retx_block_a:
        assert property (retransmit_block_i [*3] |-> !input_ready_o) else $error("input ready high at mark");
endmodule // dcfpc_asserts

bind dcfpc_top dcfpc_asserts #(.OW(OW)) u_chk (.*);

// ### bench/dcfpc_port_master.sv
// Master model for one FIFO port: free-running port clock, one operation at a time.
// Assumes sys_clk_i runs far faster than the port clock.
`timescale 1ns/1ps

module dcfpc_port_master #(
    parameter HALF     = 5,
    parameter IDLE_DIR = 1'b1
) (
    // System
    input  wire        sys_clk_i,
    // Port pins
    output reg         pclk_o,
    output reg         cs_n_o,
    output reg         en_o,
    output reg         dir_o,
    output reg         mb_o,
    output reg  [35:0] data_o
);
    integer cnt = 0;

    initial begin
        pclk_o = 0;
        cs_n_o = 1;
        en_o = 0;
        dir_o = IDLE_DIR;
        mb_o = 0;
        data_o = 36'h000000000;
    end

    always @(negedge sys_clk_i) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1)
            pclk_o <= ~pclk_o;
    end

    // Pins change at the port clock fall and hold a full period around the rise
    task start(input logic c, input logic e, input logic d, input logic m, input logic [35:0] w);
        @(negedge pclk_o);
        cs_n_o = c;
        en_o = e;
        dir_o = d;
        mb_o = m;
        data_o = w;
        @(posedge pclk_o);
        repeat (4) @(negedge sys_clk_i);
    endtask

    // Released data shows the inverse so a stale word cannot pass
    task stop;
        @(negedge pclk_o);
        cs_n_o = 1;
        en_o = 0;
        dir_o = IDLE_DIR;
        mb_o = 0;
        data_o = ~data_o;
        repeat (3) @(negedge sys_clk_i);
    endtask
endmodule // dcfpc_port_master

// ### bench/testbench.sv
// Self-checking bench for dcfpc_top: offset modes, serial load, mailboxes, FIFO fill and drain.
// Two port master models drive the ports; the bench drives reset and the flag select pins.
`timescale 1ns/1ps

module testbench;
    logic        sys_clk_i = 0, rst_i = 1, dev_reset_n_i = 1, retransmit_block_i = 0;
    logic        flag_sel_hi_serial_en_n_i = 0, flag_sel_lo_serial_bit_i = 0;
    logic        port_a_clock_i, port_a_chip_select_n_i, port_a_master_enable_i, port_a_write_not_read_i;
    logic        port_b_clock_i, port_b_chip_select_n_i, port_b_master_enable_i, port_b_read_not_write_i;
    logic        port_a_mailbox_select_i, port_b_mailbox_select_i, port_a_data_oe_o, port_b_data_oe_o;
    logic        input_ready_o, b_to_a_mailbox_flag_n_o, a_to_b_mailbox_flag_n_o, fifo_not_empty_o;
    logic [35:0] port_a_data_i, port_a_data_o, port_b_data_i, port_b_data_o;
    logic [1:0]  offset_mode_o;
    logic [8:0]  almost_full_offset_o, almost_empty_offset_o;
    integer      fails = 0, n_tests = 0, i;

    dcfpc_top u_dut (.*);
    dcfpc_port_master #(.HALF(5), .IDLE_DIR(1'b1)) u_pa (.sys_clk_i(sys_clk_i), .pclk_o(port_a_clock_i),
        .cs_n_o(port_a_chip_select_n_i), .en_o(port_a_master_enable_i), .dir_o(port_a_write_not_read_i),
        .mb_o(port_a_mailbox_select_i), .data_o(port_a_data_i));
    dcfpc_port_master #(.HALF(6), .IDLE_DIR(1'b0)) u_pb (.sys_clk_i(sys_clk_i), .pclk_o(port_b_clock_i),
        .cs_n_o(port_b_chip_select_n_i), .en_o(port_b_master_enable_i), .dir_o(port_b_read_not_write_i),
        .mb_o(port_b_mailbox_select_i), .data_o(port_b_data_i));

    always #4 sys_clk_i = ~sys_clk_i;

    task check(input logic [35:0] seen, input logic [35:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask

    task final_report;
        $display("compares %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task dev_rst(input logic [1:0] m);
        @(negedge sys_clk_i);
        {flag_sel_hi_serial_en_n_i, flag_sel_lo_serial_bit_i} = m;
        dev_reset_n_i = 0;
        repeat (12) @(negedge sys_clk_i);
        check(input_ready_o, 0, "ir in reset");
        check({a_to_b_mailbox_flag_n_o, b_to_a_mailbox_flag_n_o}, 2'h3, "flags in reset");
        dev_reset_n_i = 1;
        repeat (12) @(negedge sys_clk_i);
        {flag_sel_hi_serial_en_n_i, flag_sel_lo_serial_bit_i} = 2'h2;
        check(offset_mode_o, m, "mode");
        repeat (30) @(negedge sys_clk_i);
    endtask

    task test_presets;
        for (int m = 0; m < 3; m++) begin
            dev_rst(m[1:0]);
            check({almost_full_offset_o, almost_empty_offset_o},
                {2{m == 2 ? 9'h040 : m == 1 ? 9'h008 : 9'h000}}, "preset");
            check(input_ready_o, 1, "ir after reset");
        end
    endtask

    // Nineteen bits: the last one must be ignored
    task test_serial;
        logic [18:0] bits;
        bits = 19'h5A5C3;
        dev_rst(2'h3);
        for (int k = 18; k >= 0; k--) begin
            @(negedge port_a_clock_i);
            flag_sel_hi_serial_en_n_i = 0;
            flag_sel_lo_serial_bit_i = bits[k];
        end
        @(negedge port_a_clock_i);
        flag_sel_hi_serial_en_n_i = 1;
        repeat (30) @(negedge sys_clk_i);
        check({almost_full_offset_o, almost_empty_offset_o}, bits[18:1], "serial offsets");
        check(input_ready_o, 1, "ir after serial load");
    endtask

    task test_mailbox;
        u_pa.start(1, 1, 1, 1, 36'h9A5C3E1F7);
        u_pa.stop;
        check(a_to_b_mailbox_flag_n_o, 1, "write while deselected");
        u_pa.start(0, 0, 1, 1, 36'h9A5C3E1F7);
        u_pa.stop;
        check(a_to_b_mailbox_flag_n_o, 1, "write while disabled");
        u_pa.start(0, 1, 1, 1, 36'h9A5C3E1F7);
        check(port_a_data_oe_o, 0, "A drives on write");
        u_pa.stop;
        check({a_to_b_mailbox_flag_n_o, fifo_not_empty_o}, 2'h0, "A mail write");
        u_pb.start(0, 1, 1, 1, 36'h0);
        check(port_b_data_oe_o, 1, "B read drive");
        check(port_b_data_o, 36'h9A5C3E1F7, "B mail read");
        u_pb.stop;
        check(a_to_b_mailbox_flag_n_o, 1, "A-to-B flag after read");
        u_pb.start(1, 1, 0, 1, 36'h65A3C1E08);
        u_pb.stop;
        check(b_to_a_mailbox_flag_n_o, 1, "B write while deselected");
        u_pb.start(0, 0, 0, 1, 36'h65A3C1E08);
        u_pb.stop;
        check(b_to_a_mailbox_flag_n_o, 1, "B write while disabled");
        u_pb.start(0, 1, 0, 1, 36'h65A3C1E08);
        check(port_b_data_oe_o, 0, "B drives on write");
        u_pb.stop;
        check(b_to_a_mailbox_flag_n_o, 0, "B mail write");
        u_pb.start(1, 1, 1, 1, 36'h0);
        check(port_b_data_oe_o, 0, "B drives deselected");
        u_pb.stop;
        u_pa.start(1, 1, 0, 1, 36'h0);
        check(port_a_data_oe_o, 0, "A drives deselected");
        u_pa.stop;
        check(b_to_a_mailbox_flag_n_o, 0, "read while deselected");
        u_pa.start(0, 1, 0, 1, 36'h0);
        check(port_a_data_oe_o, 1, "A read drive");
        check(port_a_data_o, 36'h65A3C1E08, "A mail read");
        u_pa.stop;
        check(b_to_a_mailbox_flag_n_o, 1, "B-to-A flag after read");
    endtask

    // Fill past full with port B stalled, then drain in order
    task test_fifo;
        for (i = 0; i < 17; i++) begin
            u_pa.start(0, 1, 1, 0, 36'hA00000000 + i);
            u_pa.stop;
            check(input_ready_o, i < 15, "ir while filling");
        end
        for (i = 0; i < 16; i++) begin
            check(port_b_data_o, 36'hA00000000 + i, "fifo word");
            u_pb.start(0, 1, 1, 0, 36'h0);
            u_pb.stop;
        end
        check({fifo_not_empty_o, input_ready_o}, 2'h1, "write at full dropped");
        retransmit_block_i = 1;
        u_pa.start(0, 1, 1, 0, 36'h000000005);
        check(input_ready_o, 0, "ir at mark");
        u_pa.stop;
        check(fifo_not_empty_o, 0, "write at mark");
        retransmit_block_i = 0;
    endtask

    initial begin
        repeat (5) @(negedge sys_clk_i);
        rst_i = 0;
        test_presets;
        test_serial;
        test_mailbox;
        test_fifo;
        final_report;
    end

    initial begin
        #200000;
        fails++;
        final_report;
    end
endmodule // testbench
